// File: logic/crc_pkg.sv
package crc_pkg;

  // Special function register map
  localparam logic [7:0] CTRL_ADDR     = 8'hB9;
  localparam logic [7:0] CTRL_PAGE     = 8'h00;
  localparam logic [7:0] PWM_CFG_ADDR  = 8'hB9;
  localparam logic [7:0] PWM_CFG_PAGE  = 8'h0F;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] PWM_CFG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Control register fields
  localparam int CTRL_SINK_BIT  = 7;
  localparam int CTRL_SIZE_BIT  = 6;
  localparam int CTRL_COUNT_MSB = 5;
  localparam int CTRL_COUNT_LSB = 0;

  // Configuration register fields
  localparam int CFG_ENABLE_BIT = 7;
  localparam int CFG_UNUSED_MSB = 6;
  localparam int CFG_UNUSED_LSB = 3;
  localparam int CFG_SEL_MSB    = 2;
  localparam int CFG_SEL_LSB    = 0;

  // Step sizes in microamps and the fine source weight in steps
  localparam logic [3:0] LOW_POWER_STEP_UA    = 4'h1;
  localparam logic [3:0] HIGH_CURRENT_STEP_UA = 4'h8;
  localparam logic [5:0] FINE_WEIGHT_STEPS    = 6'h02;
  localparam logic [5:0] COUNT_OFF            = 6'h00;

  // Number of counter array compare outputs and the highest legal select code
  localparam int         NUM_COMPARE_OUTPUTS = 6;
  localparam logic [2:0] SEL_MAX             = 3'h5;

  typedef struct packed {
    logic       sink;
    logic       step_size_select;
    logic [5:0] step_count;
  } crc_ctrl_t;

  typedef struct packed {
    logic       fine_tune_enable;
    logic [2:0] fine_tune_source_select;
  } crc_cfg_t;

endpackage

// File: logic/crc_fine_gate.sv
`timescale 1ns/1ns
`default_nettype none

module crc_fine_gate #(
  parameter int NUM_SRC = crc_pkg::NUM_COMPARE_OUTPUTS
) (
  // Clock, reset and clock enable
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  // Configuration
  input  wire crc_pkg::crc_cfg_t  cfg,
  input  wire logic               active,
  // Compare outputs and gate
  input  wire logic [NUM_SRC-1:0] compare_in,
  output logic                    gate
);

  // Refused at elaboration: the select field cannot address more than eight sources
  if (NUM_SRC < 1 || NUM_SRC > 8) begin : g_num_src_check
    $error("crc_fine_gate: NUM_SRC must be 1 to 8");
  end

  logic gate_r;
  logic gate_nxt;

  always_comb begin
    gate_nxt = 1'b0;
    if (cfg.fine_tune_enable && active) begin
      if (cfg.fine_tune_source_select <= crc_pkg::SEL_MAX &&
          32'(cfg.fine_tune_source_select) < NUM_SRC) begin
        gate_nxt = compare_in[cfg.fine_tune_source_select];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate_r <= 1'b0;
    end else if (ce) begin
      gate_r <= gate_nxt;
    end
  end

  assign gate = gate_r;

endmodule

`default_nettype wire

// File: logic/crc_top.sv
`timescale 1ns/1ns
`default_nettype none

module crc_top (
  // Clock, reset and clock enable
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       CE,
  // Special function register port
  input  wire logic [7:0] SFR_PAGE,
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic       SFR_WR,
  input  wire logic       SFR_RD,
  input  wire logic [7:0] SFR_WDATA,
  output logic      [7:0] SFR_RDATA,
  // Counter array compare outputs
  input  wire logic [5:0] COMPARE_IN,
  // Analog control
  output logic            IREF_ACTIVE,
  output logic            IREF_SINK,
  output logic            IREF_HIGH_CURRENT,
  output logic      [5:0] IREF_STEP_COUNT,
  output logic            IREF_FINE_GATE,
  output logic      [9:0] IREF_CURRENT_UA
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [9:0] step_current(input logic [5:0] steps,
                                              input logic       high);
    logic [3:0] size;
    size = high ? crc_pkg::HIGH_CURRENT_STEP_UA : crc_pkg::LOW_POWER_STEP_UA;
    step_current = 10'(steps) * 10'(size);
  endfunction

  function automatic logic hit(input logic [7:0] page, input logic [7:0] addr,
                               input logic [7:0] want_page,
                               input logic [7:0] want_addr);
    hit = (page == want_page) && (addr == want_addr);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  crc_pkg::crc_ctrl_t ctrl_r;
  crc_pkg::crc_ctrl_t ctrl_nxt;
  crc_pkg::crc_cfg_t  cfg_r;
  crc_pkg::crc_cfg_t  cfg_nxt;
  logic [7:0]         rdata_r;
  logic [7:0]         rdata_nxt;
  logic               ctrl_sel;
  logic               cfg_sel;

  assign ctrl_sel = hit(SFR_PAGE, SFR_ADDR, crc_pkg::CTRL_PAGE, crc_pkg::CTRL_ADDR);
  assign cfg_sel  = hit(SFR_PAGE, SFR_ADDR, crc_pkg::PWM_CFG_PAGE, crc_pkg::PWM_CFG_ADDR);

  always_comb begin
    ctrl_nxt  = ctrl_r;
    cfg_nxt   = cfg_r;
    rdata_nxt = rdata_r;
    if (SFR_WR && ctrl_sel) begin
      ctrl_nxt.sink             = SFR_WDATA[crc_pkg::CTRL_SINK_BIT];
      ctrl_nxt.step_size_select = SFR_WDATA[crc_pkg::CTRL_SIZE_BIT];
      ctrl_nxt.step_count = SFR_WDATA[crc_pkg::CTRL_COUNT_MSB:crc_pkg::CTRL_COUNT_LSB];
    end
    if (SFR_WR && cfg_sel) begin
      cfg_nxt.fine_tune_enable        = SFR_WDATA[crc_pkg::CFG_ENABLE_BIT];
      cfg_nxt.fine_tune_source_select = SFR_WDATA[crc_pkg::CFG_SEL_MSB:crc_pkg::CFG_SEL_LSB];
    end
    if (SFR_RD) begin
      if (ctrl_sel) begin
        rdata_nxt = ctrl_r;
      end else if (cfg_sel) begin
        rdata_nxt = crc_pkg::PWM_CFG_RESET;
        rdata_nxt[crc_pkg::CFG_ENABLE_BIT] = cfg_r.fine_tune_enable;
        rdata_nxt[crc_pkg::CFG_SEL_MSB:crc_pkg::CFG_SEL_LSB] = cfg_r.fine_tune_source_select;
        rdata_nxt[crc_pkg::CFG_UNUSED_MSB:crc_pkg::CFG_UNUSED_LSB] = 4'h0;
      end else begin
        rdata_nxt = crc_pkg::UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_r  <= crc_pkg::CTRL_RESET;
      cfg_r.fine_tune_enable        <= crc_pkg::PWM_CFG_RESET[crc_pkg::CFG_ENABLE_BIT];
      cfg_r.fine_tune_source_select <=
        crc_pkg::PWM_CFG_RESET[crc_pkg::CFG_SEL_MSB:crc_pkg::CFG_SEL_LSB];
      rdata_r <= crc_pkg::UNMAPPED_READ;
    end else if (CE) begin
      ctrl_r  <= ctrl_nxt;
      cfg_r   <= cfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign SFR_RDATA = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Fine tuning gate

  logic active;
  logic fine_gate;

  assign active = (ctrl_r.step_count != crc_pkg::COUNT_OFF);

  crc_fine_gate #(
    .NUM_SRC (crc_pkg::NUM_COMPARE_OUTPUTS)
  ) u_fine_gate (
    .clk        (CLK),
    .rst        (RST),
    .ce         (CE),
    .cfg        (cfg_r),
    .active     (active),
    .compare_in (COMPARE_IN),
    .gate       (fine_gate)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Analog control outputs
  // Registered so the analog side never sees decode glitches.

  logic       active_r;
  logic       active_nxt;
  logic       sink_r;
  logic       sink_nxt;
  logic       high_r;
  logic       high_nxt;
  logic [5:0] count_r;
  logic [5:0] count_nxt;
  logic [9:0] current_r;
  logic [9:0] current_nxt;

  always_comb begin
    active_nxt = active;
    sink_nxt   = ctrl_r.sink;
    high_nxt   = ctrl_r.step_size_select;
    count_nxt  = ctrl_r.step_count;
    current_nxt = step_current(ctrl_r.step_count, ctrl_r.step_size_select);
    if (fine_gate) begin
      current_nxt = current_nxt +
                    step_current(crc_pkg::FINE_WEIGHT_STEPS, ctrl_r.step_size_select);
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      active_r  <= 1'b0;
      sink_r    <= 1'b0;
      high_r    <= 1'b0;
      count_r   <= crc_pkg::COUNT_OFF;
      current_r <= 10'h000;
    end else if (CE) begin
      active_r  <= active_nxt;
      sink_r    <= sink_nxt;
      high_r    <= high_nxt;
      count_r   <= count_nxt;
      current_r <= current_nxt;
    end
  end

  assign IREF_ACTIVE       = active_r;
  assign IREF_SINK         = sink_r;
  assign IREF_HIGH_CURRENT = high_r;
  assign IREF_STEP_COUNT   = count_r;
  assign IREF_FINE_GATE    = fine_gate;
  assign IREF_CURRENT_UA   = current_r;

endmodule

`default_nettype wire

// File: bench/crc_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module crc_top_asserts (
  // Clock and control
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       CE,
  // Register port
  input wire logic [7:0] SFR_PAGE,
  input wire logic [7:0] SFR_ADDR,
  input wire logic       SFR_WR,
  input wire logic       SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  input wire logic [7:0] SFR_RDATA,
  // Analog side
  input wire logic [5:0] COMPARE_IN,
  input wire logic       IREF_ACTIVE,
  input wire logic       IREF_SINK,
  input wire logic       IREF_HIGH_CURRENT,
  input wire logic [5:0] IREF_STEP_COUNT,
  input wire logic       IREF_FINE_GATE,
  input wire logic [9:0] IREF_CURRENT_UA
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic ctl_wr;
  assign ctl_wr = CE && SFR_WR && SFR_PAGE == 8'h00 && SFR_ADDR == 8'hB9;
  //////////////////////////////////////////
  chk_active_count: assert property (IREF_ACTIVE == (IREF_STEP_COUNT != 6'h00))
    else $error("active flag disagrees with count");
  chk_zero_off: assert property ((ctl_wr && SFR_WDATA == 8'h00) ##1 (CE && !SFR_WR)
    |=> !IREF_ACTIVE) else $error("zero write left reference on");
  chk_sink_dir: assert property (ctl_wr ##1 (CE && !SFR_WR)
    |=> {IREF_SINK, 7'h00} == ($past(SFR_WDATA, 2) & 8'h80)) else $error("direction wrong");
  chk_size_count: assert property (ctl_wr ##1 (CE && !SFR_WR)
    |=> {1'b0, IREF_HIGH_CURRENT, IREF_STEP_COUNT} == ($past(SFR_WDATA, 2) & 8'h7F))
    else $error("size or count wrong");
  chk_current_sum: assert property ($past(CE) |-> IREF_CURRENT_UA ==
    (({4'h0, IREF_STEP_COUNT} + ($past(IREF_FINE_GATE) ? 10'h002 : 10'h000))
    << (IREF_HIGH_CURRENT ? 3 : 0))) else $error("current magnitude wrong");
  chk_gate_cause: assert property ($past(CE) && IREF_FINE_GATE
    |-> $past(COMPARE_IN) != 6'h00) else $error("gate on without compare input");
  chk_cfg_unused: assert property (CE && SFR_RD && SFR_PAGE == 8'h0F && SFR_ADDR == 8'hB9
    |=> SFR_RDATA[6:3] == 4'h0) else $error("unused bits read non-zero");
  chk_low_limit: assert property (!IREF_HIGH_CURRENT |-> IREF_CURRENT_UA <= 10'h041)
    else $error("low power current too high");
  cov_gate: cover property (IREF_FINE_GATE);
  cov_sink: cover property (IREF_SINK && IREF_ACTIVE);
  cov_full: cover property (IREF_HIGH_CURRENT && IREF_STEP_COUNT == 6'h3F);
endmodule
bind crc_top crc_top_asserts u_crc_top_asserts (.*);
`default_nettype wire

// File: bench/tb_crc_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_crc_top;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, g;
  logic [7:0]  pg = 8'h00, ad = 8'hB9, wd = 8'h00, rdat, d, v;
  logic [5:0]  cmp = 6'h00, cnt;
  logic [9:0]  ua;
  logic        act, snk, hic, gt;
  logic [31:0] s = 32'h329B3BE7;
  logic [7:0]  cn [5] = '{8'h3F, 8'hFF, 8'h00, 8'h7F, 8'hC1};
  int          num_errors = 0, compares = 0, cyc = 0;
  always #10 clk = ~clk;
  crc_top u_crc_top (.CLK(clk), .RST(rst), .CE(ce), .SFR_PAGE(pg), .SFR_ADDR(ad),
    .SFR_WR(wr), .SFR_RD(rd), .SFR_WDATA(wd), .SFR_RDATA(rdat), .COMPARE_IN(cmp),
    .IREF_ACTIVE(act), .IREF_SINK(snk), .IREF_HIGH_CURRENT(hic), .IREF_STEP_COUNT(cnt),
    .IREF_FINE_GATE(gt), .IREF_CURRENT_UA(ua));
  //////////////////////////////////////////
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic logic [9:0] exp_ua(input logic [7:0] c);
    return {4'h0, c[5:0]} << (c[6] ? 3 : 0);
  endfunction
  task automatic check(input logic [9:0] seen, input logic [9:0] want);
    compares++;
    if (seen !== want) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, seen, want);
    end
  endtask
  // One strobe, then wait until outputs and current have settled
  task automatic acc(input logic w, input logic [7:0] p, input logic [7:0] data);
    @(posedge clk);
    pg <= p;
    wd <= data;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 d = rdat;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      give_verdict();
    end
  end
  //////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    acc(1'b0, 8'h00, 8'h00);
    check(d, 8'h00);
    acc(1'b0, 8'h0F, 8'h00);
    check(d, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      v = (i < 5) ? cn[i] : 8'(rnd());
      acc(1'b1, 8'h00, v);
      check(act, v[5:0] != 6'h00);
      check(snk, v[7]);
      check({hic, cnt}, v[6:0]);
      check(ua, exp_ua(v));
      acc(1'b0, 8'h00, 8'h00);
      check(d, v);
    end
    $display("control test done");
    // Low bits 00 so full duty on the gate must match low bits 10
    acc(1'b1, 8'h00, 8'h04);
    for (int k = 0; k < 32; k++) begin
      @(posedge clk) cmp <= k[4] ? ~(6'h01 << k[2:0]) : (6'h01 << k[2:0]);
      acc(1'b1, 8'h0F, {k[3], 4'hF, k[2:0]});
      g = k[3] & !k[4] & (k[2:0] < 3'h6);
      check(gt, g);
      check(ua, g ? exp_ua(8'h06) : exp_ua(8'h04));
      acc(1'b0, 8'h0F, 8'h00);
      check(d, {k[3], 4'h0, k[2:0]});
    end
    // High current steps scale the fine source too; a zero count must drop the gate
    acc(1'b1, 8'h00, 8'h44);
    acc(1'b1, 8'h0F, 8'h80);
    check(gt, 1'b1);
    check(ua, exp_ua(8'h46));
    acc(1'b1, 8'h00, 8'h40);
    check(act, 1'b0);
    check(gt, 1'b0);
    check(ua, 10'h000);
    $display("fine tune test done");
    // Unmapped page and frozen clock enable must both leave state alone
    acc(1'b1, 8'h01, 8'hFF);
    acc(1'b0, 8'h01, 8'h00);
    check(d, 8'h00);
    @(posedge clk) ce <= 1'b0;
    acc(1'b1, 8'h00, 8'hFF);
    @(posedge clk) ce <= 1'b1;
    acc(1'b0, 8'h00, 8'h00);
    check(d, 8'h40);
    $display("refusal test done");
    give_verdict();
  end
endmodule
`default_nettype wire
